// >>> verilog/rsit_seq.sv
// Reset, stop recovery and interrupt service sequencer
// Functional notes
// - Outputs reach reset value without clock
// - Internal reset holds two cycles plus lock
// - Service starts no sooner than latency
// - Stop wake held 128K or 25 cycles
// - PLL off in stop unless keep bit
// - PLL bypassed adds no lock wait
// - Handler output valid within latency bound
// - Interrupt service spacing twelve or eight cycles
// - DMA service spacing six seven two three
`timescale 1ns/10ps
`include "rsit_defs.svh"
module rsit_seq #(
    parameter int LOCK_CYC = `RSIT_LOCK_CYC,
    parameter int STOP_LONG_CYC = `RSIT_STOP_LONG_CYC,
    parameter int CNT_W = 18
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire rsit_pkg::rsit_cfg_type cfg,
    input wire logic stop_req,
    input wire logic wake_level,
    input wire logic irq_edge_pin,
    input wire rsit_pkg::rsit_irq_type irq_req,
    input wire rsit_pkg::rsit_dma_type dma_req,
    output logic sync_reset_ff,
    output logic pll_power_ff,
    output logic core_run_ff,
    output logic irq_service_ff,
    output logic gpo_update_ff,
    output rsit_pkg::rsit_irq_type irq_grant_ff,
    output rsit_pkg::rsit_dma_type dma_grant_ff
);
    rsit_pkg::rsit_state_type state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic pll_was_off_ff;
    logic edge_prev_ff;
    logic [3:0] lat_cnt_ff;
    logic lat_busy_ff;
    wire logic cnt_done = (cnt_ff == '0);
    wire logic edge_hit = irq_edge_pin && !edge_prev_ff;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = (n > 0) ? CNT_W'(n - 1) : '0;
    endfunction

    // Sequencing state; async reset forces RSIT_RESET and the reset count at once
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= rsit_pkg::RSIT_RESET;
            cnt_ff <= CNT_W'(`RSIT_SYNC_RST_CYC - 1);
            pll_was_off_ff <= 1'b1;
        end else begin
            case (state_ff)
                rsit_pkg::RSIT_RESET: begin
                    if (!cnt_done) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else if (cfg.pll_en && pll_was_off_ff) begin
                        state_ff <= rsit_pkg::RSIT_LOCK;
                        cnt_ff <= cyc(LOCK_CYC);
                    end else begin
                        state_ff <= rsit_pkg::RSIT_RUN;
                    end
                end
                rsit_pkg::RSIT_RUN: begin
                    pll_was_off_ff <= 1'b0;
                    if (stop_req) begin
                        state_ff <= rsit_pkg::RSIT_STOP;
                        pll_was_off_ff <= cfg.pll_en && !cfg.pll_keep;
                        cnt_ff <= cfg.stop_delay_off ? cyc(`RSIT_STOP_SHORT_CYC)
                                                     : cyc(STOP_LONG_CYC);
                    end
                end
                rsit_pkg::RSIT_STOP: begin
                    if (wake_level) begin
                        state_ff <= rsit_pkg::RSIT_WAKE;
                    end
                end
                rsit_pkg::RSIT_WAKE: begin
                    if (!wake_level) begin
                        state_ff <= rsit_pkg::RSIT_STOP;
                        cnt_ff <= cfg.stop_delay_off ? cyc(`RSIT_STOP_SHORT_CYC)
                                                     : cyc(STOP_LONG_CYC);
                    end else if (!cnt_done) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else if (pll_was_off_ff && cfg.pll_en) begin
                        state_ff <= rsit_pkg::RSIT_LOCK;
                        cnt_ff <= cyc(LOCK_CYC);
                    end else begin
                        state_ff <= rsit_pkg::RSIT_RUN;
                    end
                end
                rsit_pkg::RSIT_LOCK: begin
                    if (!cnt_done) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        state_ff <= rsit_pkg::RSIT_RUN;
                        pll_was_off_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= rsit_pkg::RSIT_RESET;
                end
            endcase
        end
    end

    // Outputs decoded into flops from the current state register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_reset_ff <= 1'b1;
            core_run_ff <= 1'b0;
            pll_power_ff <= 1'b0;
        end else begin
            sync_reset_ff <= (state_ff == rsit_pkg::RSIT_RESET) ||
                ((state_ff == rsit_pkg::RSIT_LOCK) && pll_was_off_ff && !core_run_ff &&
                 sync_reset_ff);
            core_run_ff <= (state_ff == rsit_pkg::RSIT_RUN) && !stop_req;
            pll_power_ff <= cfg.pll_en &&
                !((state_ff == rsit_pkg::RSIT_STOP || state_ff == rsit_pkg::RSIT_WAKE)
                  && !cfg.pll_keep);
        end
    end

    // Edge interrupt latency: service after fixed count, one at a time
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            edge_prev_ff <= 1'b0;
            lat_cnt_ff <= 4'h0;
            lat_busy_ff <= 1'b0;
            irq_service_ff <= 1'b0;
            gpo_update_ff <= 1'b0;
        end else begin
            edge_prev_ff <= irq_edge_pin;
            irq_service_ff <= 1'b0;
            gpo_update_ff <= irq_service_ff;
            if (!lat_busy_ff && edge_hit && core_run_ff) begin
                lat_busy_ff <= 1'b1;
                lat_cnt_ff <= 4'(`RSIT_IRQ_DLY_CYC - 2);
            end else if (lat_busy_ff) begin
                if (lat_cnt_ff == 4'h0) begin
                    lat_busy_ff <= 1'b0;
                    irq_service_ff <= 1'b1;
                end else begin
                    lat_cnt_ff <= lat_cnt_ff - 4'h1;
                end
            end
        end
    end

    // Service rate limiters
    rsit_rate_gate #(.GAP(`RSIT_IRQ_GAP_LEVEL)) u_irq_per (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(irq_req.irq_periph),
        .grant_ff(irq_grant_ff.irq_periph));
    rsit_rate_gate #(.GAP(`RSIT_IRQ_GAP_LEVEL)) u_irq_lvl (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(irq_req.irq_level),
        .grant_ff(irq_grant_ff.irq_level));
    rsit_rate_gate #(.GAP(`RSIT_IRQ_GAP_EDGE)) u_irq_dma (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(irq_req.irq_dma),
        .grant_ff(irq_grant_ff.irq_dma));
    rsit_rate_gate #(.GAP(`RSIT_IRQ_GAP_EDGE)) u_irq_edg (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(irq_req.irq_edge),
        .grant_ff(irq_grant_ff.irq_edge));
    rsit_rate_gate #(.GAP(`RSIT_DMA_GAP_RD)) u_dma_rd (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(dma_req.dma_rd),
        .grant_ff(dma_grant_ff.dma_rd));
    rsit_rate_gate #(.GAP(`RSIT_DMA_GAP_WR)) u_dma_wr (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(dma_req.dma_wr),
        .grant_ff(dma_grant_ff.dma_wr));
    rsit_rate_gate #(.GAP(`RSIT_DMA_GAP_TMR)) u_dma_tmr (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(dma_req.dma_tmr),
        .grant_ff(dma_grant_ff.dma_tmr));
    rsit_rate_gate #(.GAP(`RSIT_DMA_GAP_EDGE)) u_dma_edg (.sys_clk(sys_clk),
        .resetn(resetn), .enable(core_run_ff), .req(dma_req.dma_edge),
        .grant_ff(dma_grant_ff.dma_edge));

    sequence s_edge_taken;
        !lat_busy_ff && edge_hit && core_run_ff;
    endsequence

    sequence s_svc_quiet;
        !irq_service_ff [*8] ##1 !irq_service_ff [*2];
    endsequence

    a_irq_latency: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_edge_taken |=> s_svc_quiet ##1 irq_service_ff)
        else $error("interrupt service latency wrong");
    a_gpo_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq_service_ff |=> gpo_update_ff) else $error("output update missing");
    a_reset_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(resetn) |-> sync_reset_ff [*2]) else $error("sync reset too short");
    a_stop_short: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == rsit_pkg::RSIT_STOP && wake_level && cfg.stop_delay_off
         && !pll_was_off_ff) |-> !core_run_ff [*8])
        else $error("stop exit too early");
    a_pll_off_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == rsit_pkg::RSIT_STOP && !cfg.pll_keep) |=> !pll_power_ff)
        else $error("pll powered in stop");
    a_bypass_nolock: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == rsit_pkg::RSIT_WAKE && !cfg.pll_en) |=>
        state_ff != rsit_pkg::RSIT_LOCK) else $error("lock wait in bypass");
    a_stop_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == rsit_pkg::RSIT_RUN && stop_req && cfg.stop_delay_off) |=>
        cnt_ff == cyc(`RSIT_STOP_SHORT_CYC)) else $error("stop count not reloaded");
    a_run_needs_done: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == rsit_pkg::RSIT_WAKE && !cnt_done) |=>
        state_ff != rsit_pkg::RSIT_RUN) else $error("released before terminal count");
endmodule

// >>> verilog/rsit_defs.svh
// Timing constants and field positions for the reset, stop and interrupt sequencer
`ifndef RSIT_DEFS_SVH
`define RSIT_DEFS_SVH
`define RSIT_CLK_PERIOD_NS 10
`define RSIT_SYNC_RST_CYC 2
`define RSIT_LOCK_TIME_US 500
`define RSIT_LOCK_CYC ((`RSIT_LOCK_TIME_US * 1000) / `RSIT_CLK_PERIOD_NS)
`define RSIT_STOP_LONG_CYC 131072
`define RSIT_STOP_SHORT_CYC 25
`define RSIT_IRQ_LAT_CYC 10
`define RSIT_IRQ_LAT_NS 5
`define RSIT_IRQ_DLY_CYC (`RSIT_IRQ_LAT_CYC + \
    (`RSIT_IRQ_LAT_NS + `RSIT_CLK_PERIOD_NS - 1) / `RSIT_CLK_PERIOD_NS)
`define RSIT_GPO_MAX_NS 59
`define RSIT_GPO_MAX_CYC (`RSIT_GPO_MAX_NS / `RSIT_CLK_PERIOD_NS)
`define RSIT_IRQ_GAP_LEVEL 12
`define RSIT_IRQ_GAP_EDGE 8
`define RSIT_DMA_GAP_RD 6
`define RSIT_DMA_GAP_WR 7
`define RSIT_DMA_GAP_TMR 2
`define RSIT_DMA_GAP_EDGE 3
`define RSIT_OMR_STOP_DELAY_BIT 6
`define RSIT_PLL_CONTROL_REGISTER_KEEP_BIT 12
`define RSIT_PLL_CONTROL_REGISTER_PLL_EN_BIT 13
`define RSIT_GAP_RESET 4'h0
`endif

// >>> verilog/rsit_pkg.sv
// Types shared by the reset, stop and interrupt sequencer
package rsit_pkg;
    typedef enum logic [2:0] {
        RSIT_RESET, RSIT_RUN, RSIT_STOP, RSIT_WAKE, RSIT_LOCK
    } rsit_state_type;
    typedef struct packed {
        logic stop_delay_off;
        logic pll_keep;
        logic pll_en;
    } rsit_cfg_type;
    typedef struct packed {
        logic irq_periph;
        logic irq_level;
        logic irq_dma;
        logic irq_edge;
    } rsit_irq_type;
    typedef struct packed {
        logic dma_rd;
        logic dma_wr;
        logic dma_tmr;
        logic dma_edge;
    } rsit_dma_type;
endpackage

// >>> verilog/rsit_rate_gate.sv
// Minimum-spacing gate for one request source
`timescale 1ns/10ps
`include "rsit_defs.svh"
module rsit_rate_gate #(
    parameter int GAP = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic req,
    output logic grant_ff
);
    logic [3:0] gap_cnt_ff;
    logic [3:0] nxt_gap_cnt;
    wire logic fire = enable && req && (gap_cnt_ff == `RSIT_GAP_RESET);

    always_comb begin
        nxt_gap_cnt = gap_cnt_ff;
        if (fire) begin
            nxt_gap_cnt = 4'(GAP - 1);
        end else if (gap_cnt_ff != `RSIT_GAP_RESET) begin
            nxt_gap_cnt = gap_cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_cnt_ff <= `RSIT_GAP_RESET;
            grant_ff <= 1'b0;
        end else begin
            gap_cnt_ff <= nxt_gap_cnt;
            grant_ff <= fire;
        end
    end

    // Cycles since the last grant, saturating
    logic [3:0] since_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            since_ff <= '1;
        end else if (grant_ff) begin
            since_ff <= 4'h1;
        end else if (since_ff != '1) begin
            since_ff <= since_ff + 4'h1;
        end
    end

    a_gap_spacing: assert property (@(posedge sys_clk) disable iff (!resetn)
        grant_ff |-> since_ff >= 4'(GAP)) else $error("grants closer than gap");
endmodule

// >>> verification/rsit_host.sv
// Model of the external logic driving reset, wake and interrupt pins
`timescale 1ns/10ps
module rsit_host (
    input wire logic sys_clk,
    input wire logic rst_cmd,
    input wire logic fire,
    input wire logic wake_cmd,
    output logic resetn,
    output logic wake_level,
    output logic irq_edge_pin
);
    task automatic hold_reset();
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
    endtask
    initial begin
        irq_edge_pin = 1'b0;
        hold_reset();
    end
    always @(posedge rst_cmd) begin
        hold_reset();
    end
    // Wake stays high as long as asked, and drops mid count when wake_cmd drops
    assign wake_level = wake_cmd;
    // Fast interrupts use the edge pin only
    always @(posedge fire) begin
        irq_edge_pin = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 irq_edge_pin = 1'b0;
        repeat (2) @(posedge sys_clk);
    end
endmodule

// >>> verification/reset_stop_irq_timing_bench.sv
// Self-checking bench for the reset, stop and interrupt sequencer
`timescale 1ns/10ps
module reset_stop_irq_timing_bench;
    logic sys_clk = 1'b0;
    logic resetn, wake_level, irq_edge_pin, sync_reset_ff, pll_power_ff, core_run_ff;
    logic rst_cmd = 1'b0, fire = 1'b0, wake_cmd = 1'b0, stop_req = 1'b0;
    logic irq_service_ff, gpo_update_ff;
    logic [2:0] cfg = 3'h0;
    logic [7:0] req = 8'h00;
    rsit_pkg::rsit_irq_type irq_grant_ff;
    rsit_pkg::rsit_dma_type dma_grant_ff;
    wire [7:0] gnt = {irq_grant_ff, dma_grant_ff};
    int mismatches = 0, total_checks = 0;
    int gap[8] = '{3, 2, 7, 6, 8, 8, 12, 12};
    always #5 sys_clk = ~sys_clk;
    rsit_host u_host (.sys_clk(sys_clk), .rst_cmd(rst_cmd), .fire(fire),
        .wake_cmd(wake_cmd), .resetn(resetn), .wake_level(wake_level),
        .irq_edge_pin(irq_edge_pin));
    rsit_seq #(.LOCK_CYC(20), .STOP_LONG_CYC(40)) u_dut (.sys_clk(sys_clk),
        .resetn(resetn), .cfg(cfg), .stop_req(stop_req), .wake_level(wake_level),
        .irq_edge_pin(irq_edge_pin), .irq_req(req[7:4]), .dma_req(req[3:0]),
        .sync_reset_ff(sync_reset_ff), .pll_power_ff(pll_power_ff),
        .core_run_ff(core_run_ff), .irq_service_ff(irq_service_ff),
        .gpo_update_ff(gpo_update_ff), .irq_grant_ff(irq_grant_ff),
        .dma_grant_ff(dma_grant_ff));
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check_val(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_range(string name, int lo, int hi, int got);
        total_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic tick(inout int n);
        @(posedge sys_clk);
        #1 n++;
    endtask
    task automatic reset_test(logic [2:0] c, int lo, int hi);
        int n = 0;
        cfg = c;
        @(posedge sys_clk);
        #1 rst_cmd = 1'b1;
        #1 check_val("reset outputs", 16'h1000, {sync_reset_ff, pll_power_ff,
            core_run_ff, irq_service_ff, gpo_update_ff, gnt});
        @(posedge resetn);
        rst_cmd = 1'b0;
        while (sync_reset_ff !== 1'b0 && n < 100) tick(n);
        check_range("sync reset cycles", lo, hi, n);
        n = 0;
        while (core_run_ff !== 1'b1 && n < 10) tick(n);
        check_val("core run", 12'h1, core_run_ff);
        $display("test reset done");
    endtask
    task automatic rate_test();
        int n;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            req[i] = 1'b1;
            while (gnt[i] !== 1'b1 && n < 20) tick(n);
            n = 0;
            tick(n);
            while (gnt[i] !== 1'b1 && n < 30) tick(n);
            req[i] = 1'b0;
            check_range("grant spacing", gap[i], gap[i], n);
            repeat (14) @(posedge sys_clk);
            #1;
        end
        $display("test rate done");
    endtask
    task automatic irq_test();
        int n = 0;
        fire = 1'b1;
        while (irq_service_ff !== 1'b1 && n < 30) tick(n);
        check_range("service latency", 11, 13, n);
        tick(n);
        check_val("handler output", 12'h1, {irq_service_ff, gpo_update_ff});
        fire = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 $display("test irq done");
    endtask
    task automatic stop_test(logic [2:0] c, int exp, logic drop);
        int n = 0;
        cfg = c;
        stop_req = 1'b1;
        tick(n);
        stop_req = 1'b0;
        tick(n);
        check_val("stopped", 12'h0, core_run_ff);
        if (c[0]) check_val("pll power in stop", c[1], pll_power_ff);
        wake_cmd = 1'b1;
        if (drop) begin
            repeat (10) @(posedge sys_clk);
            #1 wake_cmd = 1'b0;
            tick(n);
            wake_cmd = 1'b1;
        end
        n = 0;
        while (core_run_ff !== 1'b1 && n < 200) tick(n);
        check_range("wake cycles", exp, exp + 3, n);
        wake_cmd = 1'b0;
        $display("test stop done");
    endtask
    initial begin
        @(posedge resetn);
        while (core_run_ff !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        reset_test(3'h0, 2, 4);
        rate_test();
        irq_test();
        stop_test(3'h4, 25, 1'b0);
        stop_test(3'h0, 40, 1'b0);
        stop_test(3'h5, 45, 1'b0);
        stop_test(3'h7, 25, 1'b0);
        stop_test(3'h4, 25, 1'b1);
        reset_test(3'h1, 22, 24);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
endmodule
